/* adcsr_pkg.sv */
// adcsr_pkg: register map, field layout and encodings of the converter configuration bank
`default_nettype none
package adcsr_pkg;

    // ****************************************
    // serial port framing
    // ****************************************
    localparam int          ADDR_W          = 13;
    localparam int          DATA_W          = 8;
    localparam int          INSTR_BITS      = 16;
    localparam int          RW_BIT          = 15;
    localparam logic [3:0]  INSTR_LAST      = 4'hF;
    localparam logic [3:0]  DATA_LAST       = 4'h7;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [12:0] ADDR_CHAN_SEL   = 13'h0005;
    localparam logic [12:0] ADDR_PWR_MODE   = 13'h0008;
    localparam logic [12:0] ADDR_SER_CTRL   = 13'h0021;
    localparam logic [12:0] ADDR_CHAN_STAT  = 13'h0022;
    localparam logic [12:0] ADDR_IO_CTRL2   = 13'h0101;
    localparam logic [12:0] ADDR_IO_CTRL3   = 13'h0102;
    localparam logic [12:0] ADDR_CAL_STAT   = 13'h0107;
    localparam logic [12:0] ADDR_CLK_MON    = 13'h0112;
    localparam logic [12:0] ADDR_REF_CTRL   = 13'h0114;

    // ****************************************
    // reset values and writable masks
    // ****************************************
    localparam logic [7:0]  RST_CHAN_SEL    = 8'h33;
    localparam logic [7:0]  RST_PWR_MODE    = 8'h00;
    localparam logic [7:0]  RST_SER_CTRL    = 8'h30;
    localparam logic [7:0]  RST_CHAN_STAT   = 8'h00;
    localparam logic [7:0]  RST_IO_CTRL     = 8'h00;
    localparam logic [7:0]  RST_CLK_MON     = 8'h07;
    localparam logic [7:0]  RST_REF_CTRL    = 8'h00;
    localparam logic [7:0]  MSK_CHAN_SEL    = 8'h33;
    localparam logic [7:0]  MSK_PWR_MODE    = 8'h03;
    localparam logic [7:0]  MSK_SER_CTRL    = 8'hF7;
    localparam logic [7:0]  MSK_IO_CTRL2    = 8'h01;
    localparam logic [7:0]  MSK_IO_CTRL3    = 8'h08;
    localparam logic [7:0]  MSK_CLK_MON     = 8'h3F;
    localparam logic [7:0]  MSK_REF_CTRL    = 8'h07;

    // ****************************************
    // fields
    // ****************************************
    localparam int          SER_LSB_FIRST   = 7;
    localparam int          SER_MODE_LSB    = 4;
    localparam int          STAT_PD_BIT     = 0;
    localparam int          STAT_ORST_BIT   = 2;
    localparam int          REC_MODE_LSB    = 3;
    localparam int          IO2_PD_DIS_BIT  = 0;
    localparam int          IO3_VCM_PD_BIT  = 3;
    localparam logic [2:0]  REC_OFF         = 3'h0;
    localparam logic [2:0]  REC_ON          = 3'h5;
    localparam logic [7:0]  CAL_BUSY_VAL    = 8'h03;
    localparam logic [7:0]  CAL_DONE_VAL    = 8'h00;

    // ****************************************
    // channels: 0 data a, 1 data b, 2 sample data clock out, 3 frame marker clock out
    // ****************************************
    localparam int          NUM_CHAN        = 4;
    localparam int          CHAN_SEL_POS [0:3] = '{0, 1, 4, 5};
    localparam logic [7:0]  DATA_HONOUR     = 8'h05;
    localparam logic [7:0]  CLK_HONOUR      = 8'h01;

    // ****************************************
    // timing
    // ****************************************
    localparam int          CAL_CYCLES_DEF  = 1024;
    localparam int          RECOVER_MEGA    = 31;
    localparam int          RECOVER_CYCLES_DEF = RECOVER_MEGA * 1_000_000;
    localparam int          CNT_W           = 25;

    typedef enum logic [2:0] {
        ADCSR_SER_SDR_BIT  = 3'b000,
        ADCSR_SER_SDR_BYTE = 3'b001,
        ADCSR_SER_DDR_BIT  = 3'b010
    } adcsr_ser_type;

    typedef enum logic [1:0] {
        ADCSR_PWR_NORMAL   = 2'b00,
        ADCSR_PWR_DOWN     = 2'b01,
        ADCSR_PWR_STANDBY  = 2'b10,
        ADCSR_PWR_DIG_RST  = 2'b11
    } adcsr_pwr_type;

    typedef enum logic [1:0] {
        ADCSR_SPI_IDLE     = 2'b00,
        ADCSR_SPI_INSTR    = 2'b01,
        ADCSR_SPI_DATA     = 2'b10,
        ADCSR_SPI_DONE     = 2'b11
    } adcsr_spi_type;

endpackage
`default_nettype wire

/* adcsr_chan_if.sv */
// adcsr_chan_if: write strobe and status between the bank and one channel slice
`timescale 1ns/10ps
`default_nettype none
interface adcsr_chan_if;
    logic       wr;
    logic [7:0] wdata;
    logic       sel;
    logic [7:0] stat;
    modport ctl  (output wr, output wdata, output sel, input stat);
    modport chan (input wr, input wdata, input sel, output stat);
endinterface
`default_nettype wire

/* adcsr_chan.sv */
// adcsr_chan: local status register of one selectable channel
`timescale 1ns/10ps
`default_nettype none
module adcsr_chan #(
    parameter logic [7:0] HONOUR = adcsr_pkg::DATA_HONOUR
) (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    adcsr_chan_if.chan      bus
);
    logic [7:0] stat_r;
    logic [7:0] stat_nxt;

    always_comb begin
        stat_nxt = stat_r;
        if (bus.wr && bus.sel) begin
            stat_nxt = bus.wdata & HONOUR;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat_r <= adcsr_pkg::RST_CHAN_STAT;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    assign bus.stat = stat_r;

    a_unsel_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !(bus.wr && bus.sel) |=> $stable(stat_r))
        else $error("unselected channel status changed");
    a_honour_subset: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        bus.wr && bus.sel |=> (stat_r & ~HONOUR) == 8'h00 && stat_r == $past(bus.wdata & HONOUR))
        else $error("channel kept a setting it does not honour");
endmodule
`default_nettype wire

/* adcsr_top.sv */
// adcsr_top: serial port slave and configuration register bank of the dual converter
// Function
// - serializer mode 000/001/010 picks lane format
// - select bits[1:0] steer data channel access
// - global registers ignore the channel selection
// - select also targets both output clock channels
// - clock channels keep a reduced setting subset
// - local status: output reset, power-down per selection
// - status 0x01 powers down only selected channel
// - select 0x31 targets both clocks and a
// - power mode 0x03 then 0x00 digital reset
// - recovery field resets 000 off, 101 on
// - power mode 00/01/10/11 decoded to controls
// - calibration status 0x03 busy, 0x00 done
// - recovery holds 31 million cycles after glitch
`timescale 1ns/10ps
`default_nettype none
module adcsr_top #(
    parameter int CAL_CYCLES     = adcsr_pkg::CAL_CYCLES_DEF,
    parameter int RECOVER_CYCLES = adcsr_pkg::RECOVER_CYCLES_DEF
) (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       sclk_i,
    input  wire logic       csb_n_i,
    input  wire logic       sdio_i,
    output logic            sdio_o,
    output logic            sdio_oe_o,
    input  wire logic       clk_glitch_i,
    output logic [3:0]      chan_pd_o,
    output logic [3:0]      chan_out_rst_o,
    output logic            pwr_down_o,
    output logic            standby_o,
    output logic            dig_reset_o,
    output logic            cal_busy_o,
    output logic            recovering_o,
    output logic            ser_ddr_o,
    output logic            ser_bytewise_o,
    output logic            ser_lsb_first_o,
    output logic            sdio_pd_dis_o,
    output logic            common_mode_voltage_pd_o,
    output logic [2:0]      ref_ctrl_o
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] sclk_s_r;
    logic [1:0] csb_s_r;
    logic [1:0] sdio_s_r;
    logic [2:0] gl_s_r;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_s_r <= 3'h0;
            csb_s_r  <= 2'h3;
            sdio_s_r <= 2'h0;
            gl_s_r   <= 3'h0;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], sclk_i};
            csb_s_r  <= {csb_s_r[0], csb_n_i};
            sdio_s_r <= {sdio_s_r[0], sdio_i};
            gl_s_r   <= {gl_s_r[1:0], clk_glitch_i};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic gl_rise;
    assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
    assign sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
    assign gl_rise   = gl_s_r[1] & ~gl_s_r[2];

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] sel_r, pwr_r, ser_r, io2_r, io3_r, mon_r, ref_r, cal_r;
    logic [7:0] sel_nxt, pwr_nxt, ser_nxt, io2_nxt, io3_nxt, mon_nxt, ref_nxt, cal_nxt;
    logic [7:0] stat_all [0:3];
    adcsr_chan_if cif [0:3] ();

    // local reads return the lowest selected channel
    function automatic logic [7:0] rd_mux(input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            adcsr_pkg::ADDR_CHAN_SEL:  v = sel_r;
            adcsr_pkg::ADDR_PWR_MODE:  v = pwr_r;
            adcsr_pkg::ADDR_SER_CTRL:  v = ser_r;
            adcsr_pkg::ADDR_IO_CTRL2:  v = io2_r;
            adcsr_pkg::ADDR_IO_CTRL3:  v = io3_r;
            adcsr_pkg::ADDR_CAL_STAT:  v = cal_r;
            adcsr_pkg::ADDR_CLK_MON:   v = mon_r;
            adcsr_pkg::ADDR_REF_CTRL:  v = ref_r;
            adcsr_pkg::ADDR_CHAN_STAT: begin
                for (int k = adcsr_pkg::NUM_CHAN - 1; k >= 0; k--) begin
                    if (sel_r[adcsr_pkg::CHAN_SEL_POS[k]]) begin
                        v = stat_all[k];
                    end
                end
            end
            default:                   v = 8'h00;
        endcase
        return v;
    endfunction

    // ****************************************
    // serial port engine
    // ****************************************
    adcsr_pkg::adcsr_spi_type st_r, st_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [15:0] instr_r, instr_nxt;
    logic [7:0]  rsh_r, rsh_nxt;
    logic        sdo_r, sdo_nxt, oe_r, oe_nxt;
    logic        wr_r, wr_nxt;
    logic [12:0] waddr_r, waddr_nxt;
    logic [7:0]  wdata_r, wdata_nxt;

    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        instr_nxt = instr_r;
        rsh_nxt   = rsh_r;
        sdo_nxt   = sdo_r;
        oe_nxt    = oe_r;
        wr_nxt    = 1'b0;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        if (csb_s_r[1]) begin
            st_nxt  = adcsr_pkg::ADCSR_SPI_IDLE;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end else begin
            case (st_r)
                adcsr_pkg::ADCSR_SPI_IDLE: begin
                    st_nxt  = adcsr_pkg::ADCSR_SPI_INSTR;
                    cnt_nxt = 4'h0;
                end
                adcsr_pkg::ADCSR_SPI_INSTR: begin
                    if (sclk_rise) begin
                        sh_nxt  = {sh_r[14:0], sdio_s_r[1]};
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == adcsr_pkg::INSTR_LAST) begin
                            instr_nxt = {sh_r[14:0], sdio_s_r[1]};
                            rsh_nxt   = rd_mux(instr_nxt[12:0]);
                            st_nxt    = adcsr_pkg::ADCSR_SPI_DATA;
                            cnt_nxt   = 4'h0;
                        end
                    end
                end
                adcsr_pkg::ADCSR_SPI_DATA: begin
                    if (instr_r[adcsr_pkg::RW_BIT] && sclk_fall) begin
                        oe_nxt  = 1'b1;
                        sdo_nxt = rsh_r[7];
                        rsh_nxt = {rsh_r[6:0], 1'b0};
                    end
                    if (sclk_rise) begin
                        sh_nxt  = {sh_r[14:0], sdio_s_r[1]};
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == adcsr_pkg::DATA_LAST) begin
                            st_nxt    = adcsr_pkg::ADCSR_SPI_DONE;
                            wr_nxt    = ~instr_r[adcsr_pkg::RW_BIT];
                            waddr_nxt = instr_r[12:0];
                            wdata_nxt = {sh_r[6:0], sdio_s_r[1]};
                        end
                    end
                end
                adcsr_pkg::ADCSR_SPI_DONE: begin
                    st_nxt = adcsr_pkg::ADCSR_SPI_DONE;
                end
                default: begin
                    st_nxt = adcsr_pkg::ADCSR_SPI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r    <= adcsr_pkg::ADCSR_SPI_IDLE;
            cnt_r   <= 4'h0;
            sh_r    <= 16'h0000;
            instr_r <= 16'h0000;
            rsh_r   <= 8'h00;
            sdo_r   <= 1'b0;
            oe_r    <= 1'b0;
            wr_r    <= 1'b0;
            waddr_r <= 13'h0000;
            wdata_r <= 8'h00;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            instr_r <= instr_nxt;
            rsh_r   <= rsh_nxt;
            sdo_r   <= sdo_nxt;
            oe_r    <= oe_nxt;
            wr_r    <= wr_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    assign sdio_o    = sdo_r;
    assign sdio_oe_o = oe_r;

    // ****************************************
    // channel slices
    // ****************************************
    for (genvar g = 0; g < adcsr_pkg::NUM_CHAN; g++) begin : g_chan
        assign cif[g].wr    = wr_r && (waddr_r == adcsr_pkg::ADDR_CHAN_STAT);
        assign cif[g].wdata = wdata_r;
        assign cif[g].sel   = sel_r[adcsr_pkg::CHAN_SEL_POS[g]];
        assign stat_all[g]  = cif[g].stat;
        assign chan_pd_o[g]      = cif[g].stat[adcsr_pkg::STAT_PD_BIT];
        assign chan_out_rst_o[g] = cif[g].stat[adcsr_pkg::STAT_ORST_BIT];
        adcsr_chan #(
            .HONOUR (g < 2 ? adcsr_pkg::DATA_HONOUR : adcsr_pkg::CLK_HONOUR)
        ) u_chan (
            .mclk_i (mclk_i),
            .rstn_i (rstn_i),
            .bus    (cif[g].chan)
        );
    end

    // ****************************************
    // global registers, calibration and recovery
    // ****************************************
    logic             cal_start;
    logic [adcsr_pkg::CNT_W-1:0] cal_cnt_r, cal_cnt_nxt, rec_cnt_r, rec_cnt_nxt;
    logic             rec_r, rec_nxt;
    logic [7:0]       dec_r, dec_nxt;

    assign cal_start = wr_r && (waddr_r == adcsr_pkg::ADDR_PWR_MODE)
                       && (wdata_r[1:0] == adcsr_pkg::ADCSR_PWR_DIG_RST);

    always_comb begin
        sel_nxt = sel_r;
        pwr_nxt = pwr_r;
        ser_nxt = ser_r;
        io2_nxt = io2_r;
        io3_nxt = io3_r;
        mon_nxt = mon_r;
        ref_nxt = ref_r;
        if (wr_r) begin
            // globals never look at the selection
            case (waddr_r)
                adcsr_pkg::ADDR_CHAN_SEL: sel_nxt = wdata_r & adcsr_pkg::MSK_CHAN_SEL;
                adcsr_pkg::ADDR_PWR_MODE: pwr_nxt = wdata_r & adcsr_pkg::MSK_PWR_MODE;
                adcsr_pkg::ADDR_SER_CTRL: ser_nxt = wdata_r & adcsr_pkg::MSK_SER_CTRL;
                adcsr_pkg::ADDR_IO_CTRL2: io2_nxt = wdata_r & adcsr_pkg::MSK_IO_CTRL2;
                adcsr_pkg::ADDR_IO_CTRL3: io3_nxt = wdata_r & adcsr_pkg::MSK_IO_CTRL3;
                adcsr_pkg::ADDR_CLK_MON:  mon_nxt = wdata_r & adcsr_pkg::MSK_CLK_MON;
                adcsr_pkg::ADDR_REF_CTRL: ref_nxt = wdata_r & adcsr_pkg::MSK_REF_CTRL;
                default:                  sel_nxt = sel_r; // status and unmapped: dropped
            endcase
        end
        cal_nxt     = cal_r;
        cal_cnt_nxt = cal_cnt_r;
        if (cal_start) begin
            cal_nxt     = adcsr_pkg::CAL_BUSY_VAL;
            cal_cnt_nxt = adcsr_pkg::CNT_W'(CAL_CYCLES - 1);
        end else if (cal_r != adcsr_pkg::CAL_DONE_VAL) begin
            if (cal_cnt_r == '0) begin
                cal_nxt = adcsr_pkg::CAL_DONE_VAL;
            end else begin
                cal_cnt_nxt = cal_cnt_r - 1'b1;
            end
        end
        rec_nxt     = rec_r;
        rec_cnt_nxt = rec_cnt_r;
        if (rec_r) begin
            if (rec_cnt_r == '0) begin
                rec_nxt = 1'b0;
            end else begin
                rec_cnt_nxt = rec_cnt_r - 1'b1;
            end
        end else if (gl_rise && mon_r[adcsr_pkg::REC_MODE_LSB +: 3] == adcsr_pkg::REC_ON) begin
            rec_nxt     = 1'b1;
            rec_cnt_nxt = adcsr_pkg::CNT_W'(RECOVER_CYCLES - 1);
        end
        // decoded controls registered so every output leaves a flop
        dec_nxt[0] = pwr_nxt[1:0] == adcsr_pkg::ADCSR_PWR_DOWN;
        dec_nxt[1] = pwr_nxt[1:0] == adcsr_pkg::ADCSR_PWR_STANDBY;
        dec_nxt[2] = pwr_nxt[1:0] == adcsr_pkg::ADCSR_PWR_DIG_RST;
        dec_nxt[3] = ser_nxt[adcsr_pkg::SER_MODE_LSB +: 3] == adcsr_pkg::ADCSR_SER_DDR_BIT;
        dec_nxt[4] = ser_nxt[adcsr_pkg::SER_MODE_LSB +: 3] == adcsr_pkg::ADCSR_SER_SDR_BYTE;
        dec_nxt[7:5] = 3'h0;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_r     <= adcsr_pkg::RST_CHAN_SEL;
            pwr_r     <= adcsr_pkg::RST_PWR_MODE;
            ser_r     <= adcsr_pkg::RST_SER_CTRL;
            io2_r     <= adcsr_pkg::RST_IO_CTRL;
            io3_r     <= adcsr_pkg::RST_IO_CTRL;
            mon_r     <= adcsr_pkg::RST_CLK_MON;
            ref_r     <= adcsr_pkg::RST_REF_CTRL;
            cal_r     <= adcsr_pkg::CAL_DONE_VAL;
            cal_cnt_r <= '0;
            rec_r     <= 1'b0;
            rec_cnt_r <= '0;
            dec_r     <= 8'h00;
        end else begin
            sel_r     <= sel_nxt;
            pwr_r     <= pwr_nxt;
            ser_r     <= ser_nxt;
            io2_r     <= io2_nxt;
            io3_r     <= io3_nxt;
            mon_r     <= mon_nxt;
            ref_r     <= ref_nxt;
            cal_r     <= cal_nxt;
            cal_cnt_r <= cal_cnt_nxt;
            rec_r     <= rec_nxt;
            rec_cnt_r <= rec_cnt_nxt;
            dec_r     <= dec_nxt;
        end
    end

    assign pwr_down_o      = dec_r[0];
    assign standby_o       = dec_r[1];
    assign dig_reset_o     = dec_r[2];
    assign ser_ddr_o       = dec_r[3];
    assign ser_bytewise_o  = dec_r[4];
    assign cal_busy_o      = cal_r[0];
    assign recovering_o    = rec_r;
    assign ser_lsb_first_o = ser_r[adcsr_pkg::SER_LSB_FIRST];
    assign sdio_pd_dis_o   = io2_r[adcsr_pkg::IO2_PD_DIS_BIT];
    assign common_mode_voltage_pd_o = io3_r[adcsr_pkg::IO3_VCM_PD_BIT];
    assign ref_ctrl_o      = ref_r[2:0];

    // ****************************************
    // checks
    // ****************************************
    a_sel_persist: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !(wr_r && waddr_r == adcsr_pkg::ADDR_CHAN_SEL) |=> $stable(sel_r))
        else $error("channel selection changed without a write");
    a_ddr_decode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ser_ddr_o == (ser_r[6:4] == 3'b010) && ser_bytewise_o == (ser_r[6:4] == 3'b001))
        else $error("serializer mode decode wrong");
    a_dig_reset: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        dig_reset_o == (pwr_r[1:0] == 2'b11) && standby_o == (pwr_r[1:0] == 2'b10))
        else $error("power mode decode wrong");
    a_cal_start: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        cal_start |=> cal_r == 8'h03 ##0 cal_busy_o)
        else $error("calibration did not start on digital reset");
    a_cal_ro: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        cal_r == 8'h00 && !cal_start |=> cal_r == 8'h00)
        else $error("calibration status changed without a digital reset");
    a_recover_off: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !rec_r && mon_r[5:3] != 3'b101 |=> !rec_r)
        else $error("recovery started while disabled");
    a_recover_len: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(rec_r) |-> rec_r [*8])
        else $error("recovery ended too early");
    a_local_route: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_r && waddr_r == adcsr_pkg::ADDR_CHAN_STAT && !sel_r[1]
        |=> $stable(chan_pd_o[1]))
        else $error("unselected channel b was written");
endmodule
`default_nettype wire

/* adcsr_host.sv */
// adcsr_host: behavioural serial port host with the shared data wire
`timescale 1ns/10ps
`default_nettype none
module adcsr_host (
    output logic       sclk_o,
    output logic       csb_n_o,
    output logic       sdio_o,
    input  wire logic  dev_d_i,
    input  wire logic  dev_oe_i,
    input  wire logic  pd_dis_i,
    output logic [7:0] rdata_o,
    output logic       rd_tgl_o
);
    logic drv = 1'b0;
    logic dat = 1'b0;
    logic tog = 1'b0;
    // ****
    // wire level: pull-down, or a moving pattern once it is disabled
    // ****
    always #5 tog = ~tog;
    assign sdio_o = dev_oe_i ? dev_d_i : drv ? dat : pd_dis_i & tog;
    initial begin
        sclk_o = 1'b0;
        csb_n_o = 1'b1;
        rdata_o = 8'h00;
        rd_tgl_o = 1'b0;
    end
    // one register per frame, sclk only moves inside it
    task xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, input int gap);
        logic [23:0] fr;
        fr = {rd, 2'b00, a, wd};
        csb_n_o = 1'b0;
        drv = 1'b1;
        for (int i = 23; i >= 0; i--) begin
            if (drv) dat = fr[i];
            #62.5 sclk_o = 1'b1;
            if (rd && i < 8) rdata_o[i] = sdio_o;
            #62.5 sclk_o = 1'b0;
            // release after the fall: the slave takes the last address bit on the rise
            if (rd && i == 8) drv = 1'b0;
        end
        drv = 1'b0;
        #62.5 csb_n_o = 1'b1;
        #(gap);
        if (rd) rd_tgl_o = ~rd_tgl_o;
    endtask
endmodule
`default_nettype wire

/* adcsr_top_tb.sv */
// adcsr_top_tb: self-checking bench of the configuration bank
`timescale 1ns/10ps
`default_nettype none
module adcsr_top_tb;
    logic        mclk = 1'b0;
    logic        rstn;
    logic        glitch;
    logic        sclk, csb_n, sdio, dev_d, dev_oe, rd_tgl;
    logic [7:0]  rdata;
    logic [3:0]  pd, orst;
    logic        pdn, stby, dig, cal, rec, ddr, byt, lsbf, pdd, common_mode_voltage;
    logic [2:0]  refc;
    logic [7:0]  d;
    logic [20:0] exp_q [$];
    logic [20:0] ent;
    int          num_errors = 0;
    int          num_checks = 0;
    logic [12:0] ra [10] = '{13'h0005, 13'h0021, 13'h0022, 13'h0101, 13'h0102,
                             13'h0107, 13'h0112, 13'h0114, 13'h0008, 13'h00FF};
    logic [7:0]  rv [10] = '{8'h33, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
    always #4 mclk = ~mclk;
    adcsr_top #(.CAL_CYCLES(4000), .RECOVER_CYCLES(20)) adcsr_top_i (
        .mclk_i(mclk), .rstn_i(rstn), .sclk_i(sclk), .csb_n_i(csb_n), .sdio_i(sdio),
        .sdio_o(dev_d), .sdio_oe_o(dev_oe), .clk_glitch_i(glitch), .chan_pd_o(pd),
        .chan_out_rst_o(orst), .pwr_down_o(pdn), .standby_o(stby), .dig_reset_o(dig),
        .cal_busy_o(cal), .recovering_o(rec), .ser_ddr_o(ddr), .ser_bytewise_o(byt),
        .ser_lsb_first_o(lsbf), .sdio_pd_dis_o(pdd), .common_mode_voltage_pd_o(common_mode_voltage),
        .ref_ctrl_o(refc));
    adcsr_host adcsr_host_i (.sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(sdio), .dev_d_i(dev_d),
        .dev_oe_i(dev_oe), .pd_dis_i(pdd), .rdata_o(rdata), .rd_tgl_o(rd_tgl));
    // ****
    // compares
    // ****
    task chk_reg(input logic [12:0] a, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD reg %h exp %h got %h", a, e, g);
        end
    endtask
    task chk_pin(input string n, input logic [3:0] e, input logic [3:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    always @(rd_tgl) begin
        if (exp_q.size() > 0) begin
            ent = exp_q.pop_front();
            chk_reg(ent[20:8], ent[7:0], rdata);
        end
    end
    task wr(input logic [12:0] a, input logic [7:0] v);
        adcsr_host_i.xfer(1'b0, a, v, 100 + ($urandom % 200));
    endtask
    task rd(input logic [12:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        adcsr_host_i.xfer(1'b1, a, 8'h00, 100);
    endtask
    task kick;
        repeat ($urandom % 8) @(negedge mclk);
        glitch = 1'b1;
        repeat (3) @(negedge mclk);
        glitch = 1'b0;
        repeat (10) @(negedge mclk);
    endtask
    task complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ****
    // sequence
    // ****
    initial begin
        void'($urandom(32'hBC2B_E8C3));
        glitch = 1'b0;
        rstn = 1'b0;
        repeat (20) @(negedge mclk);
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        foreach (ra[k]) rd(ra[k], rv[k]);
        for (int m = 0; m < 3; m++) begin
            wr(13'h0021, {m[0], m[2:0], 4'h0});
            chk_pin("ser", {1'b0, m[0], m == 1, m == 2}, {1'b0, lsbf, byt, ddr});
            rd(13'h0021, {m[0], m[2:0], 4'h0});
        end
        wr(13'h0005, 8'h02);
        wr(13'h0022, 8'h01);
        chk_pin("pd", 4'b0010, pd);
        wr(13'h0021, 8'h00);
        chk_pin("ser", 4'h0, {1'b0, lsbf, byt, ddr});
        wr(13'h0022, 8'h05);
        chk_pin("orst", 4'b0010, orst);
        wr(13'h0005, 8'h31);
        rd(13'h0005, 8'h31);
        wr(13'h0022, 8'h05);
        chk_pin("pd", 4'b1111, pd);
        chk_pin("orst", 4'b0011, orst);
        rd(13'h0022, 8'h05);
        wr(13'h0107, 8'hFF);
        rd(13'h0107, 8'h00);
        wr(13'h00FF, 8'hFF);
        rd(13'h00FF, 8'h00);
        wr(13'h0101, 8'hFF);
        wr(13'h0102, 8'hFF);
        rd(13'h0101, 8'h01);
        chk_pin("io", 4'b0011, {2'b00, common_mode_voltage, pdd});
        d = $urandom;
        wr(13'h0114, d);
        chk_pin("ref", {1'b0, d[2:0]}, {1'b0, refc});
        wr(13'h0008, 8'h03);
        chk_pin("pwr", 4'b1001, {dig, stby, pdn, cal});
        rd(13'h0107, 8'h03);
        repeat (4000) @(negedge mclk);
        rd(13'h0107, 8'h00);
        for (int m = 0; m < 3; m++) begin
            wr(13'h0008, m[7:0]);
            chk_pin("pwr", {1'b0, m == 2, m == 1, 1'b0}, {dig, stby, pdn, cal});
        end
        kick();
        chk_pin("rec", 4'h0, {3'b000, rec});
        wr(13'h0112, 8'h2F);
        kick();
        chk_pin("rec", 4'h1, {3'b000, rec});
        repeat (30) @(negedge mclk);
        chk_pin("rec", 4'h0, {3'b000, rec});
        complete_run();
    end
    // run needs about 160 us; stop a hang well after that
    initial begin
        #400_000;
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
